// ---- rtl/cmd_decode_pkg.sv ----
package cmd_decode_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses on the control bus)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_FEATURE = 8'h00;
  localparam logic [7:0] ADDR_SECCNT = 8'h04;
  localparam logic [7:0] ADDR_DEVICE = 8'h08;
  localparam logic [7:0] ADDR_COMMAND = 8'h0C;
  localparam logic [7:0] ADDR_ERROR = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_RESULT = 8'h18;
  localparam logic [7:0] ADDR_DRIVE = 8'h1C;

  // ----------------------------------------------------------------
  // opcodes and power query result values
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_MONITOR = 8'hB0;
  localparam logic [7:0] OP_OVERLAY = 8'hB1;
  localparam logic [7:0] OP_SETFEAT = 8'hEF;
  localparam logic [7:0] OP_MAXSEC = 8'hF9;
  localparam logic [7:0] OP_PWRQ = 8'hE5;
  localparam logic [7:0] OP_PWRQ_ALT = 8'h98;
  localparam logic [7:0] OP_SETMAX_EXT = 8'h37;
  localparam logic [7:0] SPIN_UP_CODE = 8'hFF;
  localparam logic [7:0] SPIN_DOWN_CODE = 8'h00;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int DEV_LBA_BIT = 6;
  localparam int DEV_RETRY_BIT = 7;
  localparam int SC_OPTION_BIT = 0;
  localparam int ERR_ABORT_BIT = 2;
  localparam int ST_ERR_BIT = 0;
  localparam int ST_RDY_BIT = 6;
  localparam int ST_BSY_BIT = 7;
  localparam logic [7:0] STATUS_RESET = 8'h40;
  localparam int DECODE_CYCLES = 2;

  // decoded subcommand identifiers
  typedef enum logic [5:0] {
    SUB_NONE = 6'h00, SUB_MON_RD_ATTR = 6'h01, SUB_MON_RD_THR = 6'h02,
    SUB_MON_AUTOSAVE = 6'h03, SUB_MON_SAVE = 6'h04,
    SUB_MON_OFFLINE_NOW = 6'h05, SUB_MON_RD_LOG = 6'h06,
    SUB_MON_WR_LOG = 6'h07, SUB_MON_ENA = 6'h08, SUB_MON_DIS = 6'h09,
    SUB_MON_STATUS = 6'h0A, SUB_MON_AUTO_OFFLINE = 6'h0B,
    SUB_WCACHE_ENA = 6'h10, SUB_WCACHE_DIS = 6'h11, SUB_XFER_MODE = 6'h12,
    SUB_APM_ENA = 6'h13, SUB_APM_DIS = 6'h14, SUB_PUIS_ENA = 6'h15,
    SUB_PUIS_DIS = 6'h16, SUB_PUIS_SPIN = 6'h17, SUB_SLINK_ENA = 6'h18,
    SUB_SLINK_DIS = 6'h19, SUB_LOOKAHEAD_ENA = 6'h1A,
    SUB_LOOKAHEAD_DIS = 6'h1B, SUB_REVERT_ENA = 6'h1C,
    SUB_REVERT_DIS = 6'h1D, SUB_MAX_PASSWD = 6'h20, SUB_MAX_LOCK = 6'h21,
    SUB_MAX_UNLOCK = 6'h22, SUB_MAX_FREEZE = 6'h23,
    SUB_OVL_RESTORE = 6'h28, SUB_OVL_FREEZE = 6'h29,
    SUB_OVL_IDENTIFY = 6'h2A, SUB_OVL_SET = 6'h2B,
    SUB_POWER_QUERY = 6'h30, SUB_PASS = 6'h3E, SUB_INVALID = 6'h3F
  } subcmd_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_DECODE = 2'b01, ST_DONE = 2'b10
  } exec_state_t;

endpackage

// ---- rtl/cmd_if.sv ----
// carries one issued command into the decoder and its answer back
interface cmd_if;
  logic [7:0] feature;
  logic [7:0] opcode;
  logic [7:0] sec_count;
  logic [7:0] device;
  cmd_decode_pkg::subcmd_t sub;
  logic lba_mode;
  logic max_option;
  modport ctrl (output feature, opcode, sec_count, device,
                input sub, lba_mode, max_option);
  modport dec (input feature, opcode, sec_count, device,
               output sub, lba_mode, max_option);
endinterface

// ---- rtl/subcmd_decoder.sv ----
module subcmd_decoder
  import cmd_decode_pkg::*;
(
  cmd_if.dec cmd
);

  // ----------------------------------------------------------------
  // feature lookups per multi-function opcode
  // ----------------------------------------------------------------
  function automatic subcmd_t monitor_sub(input logic [7:0] f);
    case (f)
      8'hD0: monitor_sub = SUB_MON_RD_ATTR;
      8'hD1: monitor_sub = SUB_MON_RD_THR;
      8'hD2: monitor_sub = SUB_MON_AUTOSAVE;
      8'hD3: monitor_sub = SUB_MON_SAVE;
      8'hD4: monitor_sub = SUB_MON_OFFLINE_NOW;
      8'hD5: monitor_sub = SUB_MON_RD_LOG;
      8'hD6: monitor_sub = SUB_MON_WR_LOG;
      8'hD8: monitor_sub = SUB_MON_ENA;
      8'hD9: monitor_sub = SUB_MON_DIS;
      8'hDA: monitor_sub = SUB_MON_STATUS;
      8'hDB: monitor_sub = SUB_MON_AUTO_OFFLINE;
      default: monitor_sub = SUB_INVALID;
    endcase
  endfunction

  function automatic subcmd_t setfeat_sub(input logic [7:0] f);
    case (f)
      8'h02: setfeat_sub = SUB_WCACHE_ENA;
      8'h82: setfeat_sub = SUB_WCACHE_DIS;
      8'h03: setfeat_sub = SUB_XFER_MODE;
      8'h05: setfeat_sub = SUB_APM_ENA;
      8'h85: setfeat_sub = SUB_APM_DIS;
      8'h06: setfeat_sub = SUB_PUIS_ENA;
      8'h86: setfeat_sub = SUB_PUIS_DIS;
      8'h07: setfeat_sub = SUB_PUIS_SPIN;
      8'h10: setfeat_sub = SUB_SLINK_ENA;
      8'h90: setfeat_sub = SUB_SLINK_DIS;
      8'hAA: setfeat_sub = SUB_LOOKAHEAD_ENA;
      8'h55: setfeat_sub = SUB_LOOKAHEAD_DIS;
      8'hCC: setfeat_sub = SUB_REVERT_ENA;
      8'h66: setfeat_sub = SUB_REVERT_DIS;
      default: setfeat_sub = SUB_INVALID;
    endcase
  endfunction

  // opcode selects the table; both power query codes share one path
  always_comb begin
    case (cmd.opcode)
      OP_MONITOR: cmd.sub = monitor_sub(cmd.feature);
      OP_SETFEAT: cmd.sub = setfeat_sub(cmd.feature);
      OP_MAXSEC: begin
        case (cmd.feature)
          8'h01: cmd.sub = SUB_MAX_PASSWD;
          8'h02: cmd.sub = SUB_MAX_LOCK;
          8'h03: cmd.sub = SUB_MAX_UNLOCK;
          8'h04: cmd.sub = SUB_MAX_FREEZE;
          default: cmd.sub = SUB_INVALID;
        endcase
      end
      OP_OVERLAY: begin
        case (cmd.feature)
          8'hC0: cmd.sub = SUB_OVL_RESTORE;
          8'hC1: cmd.sub = SUB_OVL_FREEZE;
          8'hC2: cmd.sub = SUB_OVL_IDENTIFY;
          8'hC3: cmd.sub = SUB_OVL_SET;
          default: cmd.sub = SUB_INVALID;
        endcase
      end
      OP_PWRQ, OP_PWRQ_ALT: cmd.sub = SUB_POWER_QUERY;
      default: cmd.sub = SUB_PASS;
    endcase
  end

  // addressing bit; retry bit deliberately not looked at
  assign cmd.lba_mode = cmd.device[DEV_LBA_BIT];

  // option bit only means something to set-max commands
  assign cmd.max_option = ((cmd.opcode == OP_MAXSEC) ||
                           (cmd.opcode == OP_SETMAX_EXT)) ?
                          cmd.sec_count[SC_OPTION_BIT] : 1'b0;

endmodule

// ---- rtl/ata_subcommand_power_query.sv ----
// Notes on behaviour
// - B0 with D0/D1/D5 selects monitor reads
// - B0 D2 autosave, D3 save, D4 offline
// - B0 D6 write log, D8/D9 enable/disable
// - B0 DA status, DB auto offline
// - EF 05/85 power management on/off
// - EF 06/86 standby power-up, 07 spin-up
// - EF 10/90 serial link feature on/off
// - EF AA/55 look-ahead on/off
// - EF CC/66 revert defaults on/off
// - F9 01..04 max-address security subcommands
// - B1 C0..C3 configuration overlay subcommands
// - device bit: zero CHS, one LBA
// - retry bit ignored, host should send 0
// - option bit used only for set-max
// - E5 and 98 are the power query
// - query returns FF if spinning, else 00
// - alternate opcode behaves as its primary
//
// Added by the designer: the AXI4-Lite interface to the registers and the placing of the registers.
module ata_subcommand_power_query
  import cmd_decode_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [5:0] subcmd,
  output logic subcmd_strobe,
  output logic lba_mode,
  output logic max_option
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0] feature_q, feature_d, seccnt_q, seccnt_d;
  logic [7:0] device_q, device_d, opcode_q, opcode_d;
  logic [7:0] command_error_flags_q, command_error_flags_d;
  logic [7:0] command_completion_flags_q, command_completion_flags_d;
  logic [7:0] drive_q, drive_d;
  logic [5:0] subcmd_q, subcmd_d;
  logic strobe_q, strobe_d, lba_q, lba_d, opt_q, opt_d;
  exec_state_t state_q, state_d;
  logic [1:0] cnt_q, cnt_d;
  logic aw_q, aw_d, w_q, w_d, b_q, b_d, r_q, r_d;
  logic [7:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic wr_go, rd_go, spinning;

  cmd_if cmd ();
  assign cmd.feature = feature_q;
  assign cmd.opcode = opcode_q;
  assign cmd.sec_count = seccnt_q;
  assign cmd.device = device_q;

  subcmd_decoder u_dec (
    .cmd(cmd)
  );

  // ----------------------------------------------------------------
  // bus slave and command engine
  // ----------------------------------------------------------------
  // drive bits: 0 spindle at speed, 1 standby, 2 sleep
  assign spinning = drive_q[0] && !drive_q[1] && !drive_q[2];
  assign wr_go = aw_q && w_q && !b_q;
  assign rd_go = s_axi_arvalid && !r_q;

  // one write and one read outstanding; address and data in any order
  always_comb begin
    feature_d = feature_q;
    seccnt_d = seccnt_q;
    device_d = device_q;
    opcode_d = opcode_q;
    drive_d = drive_q;
    command_error_flags_d = command_error_flags_q;
    command_completion_flags_d = command_completion_flags_q;
    subcmd_d = subcmd_q;
    strobe_d = 1'b0;
    lba_d = lba_q;
    opt_d = opt_q;
    state_d = state_q;
    cnt_d = cnt_q;
    aw_d = aw_q;
    w_d = w_q;
    b_d = b_q;
    r_d = r_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bresp_d = bresp_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    if (s_axi_awvalid && !aw_q) begin
      aw_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_q) begin
      w_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    if (b_q && s_axi_bready) begin
      b_d = 1'b0;
    end
    if (wr_go) begin
      aw_d = 1'b0;
      w_d = 1'b0;
      b_d = 1'b1;
      bresp_d = 2'b00;
      // writes while busy are dropped; task file is locked
      if (wstrb_q[0] && state_q == ST_IDLE) begin
        case (awaddr_q)
          ADDR_FEATURE: feature_d = wdata_q[7:0];
          ADDR_SECCNT: seccnt_d = wdata_q[7:0];
          ADDR_DEVICE: device_d = wdata_q[7:0];
          ADDR_DRIVE: drive_d = wdata_q[7:0];
          ADDR_COMMAND: begin
            opcode_d = wdata_q[7:0];
            state_d = ST_DECODE;
            cnt_d = 2'(DECODE_CYCLES - 1);
            command_completion_flags_d = 8'h80; // busy, others clear
            command_error_flags_d = 8'h00;
          end
          ADDR_ERROR, ADDR_STATUS, ADDR_RESULT: ;
          default: bresp_d = 2'b10;
        endcase
      end
    end
    if (r_q && s_axi_rready) begin
      r_d = 1'b0;
    end
    if (rd_go) begin
      r_d = 1'b1;
      rresp_d = 2'b00;
      case (s_axi_araddr)
        ADDR_FEATURE: rdata_d = {24'h00_0000, feature_q};
        ADDR_SECCNT: rdata_d = {24'h00_0000, seccnt_q};
        ADDR_DEVICE: rdata_d = {24'h00_0000, device_q};
        ADDR_COMMAND: rdata_d = {24'h00_0000, opcode_q};
        ADDR_ERROR: rdata_d = {24'h00_0000, command_error_flags_q};
        ADDR_STATUS: rdata_d = {24'h00_0000, command_completion_flags_q};
        ADDR_RESULT: rdata_d = {26'h000_0000, subcmd_q};
        ADDR_DRIVE: rdata_d = {24'h00_0000, drive_q};
        default: begin
          rdata_d = 32'h0000_0000;
          rresp_d = 2'b10;
        end
      endcase
    end
    // command execution
    case (state_q)
      ST_IDLE: ;
      ST_DECODE: begin
        if (cnt_q == 2'b00) begin
          state_d = ST_DONE;
        end else begin
          cnt_d = cnt_q - 2'b01;
        end
      end
      ST_DONE: begin
        state_d = ST_IDLE;
        subcmd_d = cmd.sub;
        lba_d = cmd.lba_mode;
        opt_d = cmd.max_option;
        strobe_d = 1'b1;
        command_completion_flags_d = STATUS_RESET;
        if (cmd.sub == SUB_INVALID) begin
          command_error_flags_d[ERR_ABORT_BIT] = 1'b1;
          command_completion_flags_d[ST_ERR_BIT] = 1'b1;
        end else if (cmd.sub == SUB_POWER_QUERY) begin
          seccnt_d = spinning ? SPIN_UP_CODE : SPIN_DOWN_CODE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // register everything; reset leaves drive ready and idle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      feature_q <= 8'h00;
      seccnt_q <= 8'h00;
      device_q <= 8'h00;
      opcode_q <= 8'h00;
      drive_q <= 8'h00;
      command_error_flags_q <= 8'h00;
      command_completion_flags_q <= STATUS_RESET;
      subcmd_q <= 6'h00;
      strobe_q <= 1'b0;
      lba_q <= 1'b0;
      opt_q <= 1'b0;
      state_q <= ST_IDLE;
      cnt_q <= 2'b00;
      aw_q <= 1'b0;
      w_q <= 1'b0;
      b_q <= 1'b0;
      r_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bresp_q <= 2'b00;
      rresp_q <= 2'b00;
      rdata_q <= 32'h0000_0000;
    end else begin
      feature_q <= feature_d;
      seccnt_q <= seccnt_d;
      device_q <= device_d;
      opcode_q <= opcode_d;
      drive_q <= drive_d;
      command_error_flags_q <= command_error_flags_d;
      command_completion_flags_q <= command_completion_flags_d;
      subcmd_q <= subcmd_d;
      strobe_q <= strobe_d;
      lba_q <= lba_d;
      opt_q <= opt_d;
      state_q <= state_d;
      cnt_q <= cnt_d;
      aw_q <= aw_d;
      w_q <= w_d;
      b_q <= b_d;
      r_q <= r_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bresp_q <= bresp_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
    end
  end

  // ready outputs are combinational from the holding flags
  assign s_axi_awready = !aw_q;
  assign s_axi_wready = !w_q;
  assign s_axi_bvalid = b_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = !r_q;
  assign s_axi_rvalid = r_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign subcmd = subcmd_q;
  assign subcmd_strobe = strobe_q;
  assign lba_mode = lba_q;
  assign max_option = opt_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_query_full;
    @(posedge aclk) disable iff (!aresetn)
    (state_q == ST_DONE && cmd.sub == SUB_POWER_QUERY && spinning)
      |=> seccnt_q == SPIN_UP_CODE;
  endproperty
  a_query_full: assert property (p_query_full)
    else $error("power query spinning not FF");

  property p_query_zero;
    @(posedge aclk) disable iff (!aresetn)
    (state_q == ST_DONE && cmd.sub == SUB_POWER_QUERY && !spinning)
      |=> seccnt_q == SPIN_DOWN_CODE;
  endproperty
  a_query_zero: assert property (p_query_zero)
    else $error("power query idle not zero");

  property p_alt_same;
    @(posedge aclk) disable iff (!aresetn)
    (opcode_q == OP_PWRQ_ALT || opcode_q == OP_PWRQ)
      |-> cmd.sub == SUB_POWER_QUERY;
  endproperty
  a_alt_same: assert property (p_alt_same)
    else $error("alternate opcode decoded differently");

  property p_abort;
    @(posedge aclk) disable iff (!aresetn)
    (state_q == ST_DONE && cmd.sub == SUB_INVALID)
      |=> command_error_flags_q[ERR_ABORT_BIT]
          && command_completion_flags_q[ST_ERR_BIT] && strobe_q;
  endproperty
  a_abort: assert property (p_abort)
    else $error("invalid feature not aborted");

  property p_monitor;
    @(posedge aclk) disable iff (!aresetn)
    (opcode_q == OP_MONITOR && feature_q == 8'hD5)
      |-> cmd.sub == SUB_MON_RD_LOG;
  endproperty
  a_monitor: assert property (p_monitor)
    else $error("D5 not log read");

  property p_lba;
    @(posedge aclk) disable iff (!aresetn)
    (state_q == ST_DONE) |=> lba_q == $past(device_q[DEV_LBA_BIT]);
  endproperty
  a_lba: assert property (p_lba)
    else $error("addressing mode mismatch");

  property p_option;
    @(posedge aclk) disable iff (!aresetn)
    (state_q == ST_DONE && opcode_q != OP_MAXSEC
     && opcode_q != OP_SETMAX_EXT) |=> !opt_q;
  endproperty
  a_option: assert property (p_option)
    else $error("option bit used outside set-max");

  property p_latency;
    @(posedge aclk) disable iff (!aresetn)
    (state_q == ST_IDLE && state_d == ST_DECODE) |-> ##4 strobe_q;
  endproperty
  a_latency: assert property (p_latency)
    else $error("command did not complete in time");

  c_query: cover property (@(posedge aclk) disable iff (!aresetn)
    strobe_q && subcmd_q == SUB_POWER_QUERY);
  c_abort: cover property (@(posedge aclk) disable iff (!aresetn)
    strobe_q && command_error_flags_q[ERR_ABORT_BIT]);
  c_setfeat: cover property (@(posedge aclk) disable iff (!aresetn)
    strobe_q && subcmd_q == SUB_LOOKAHEAD_ENA);

endmodule

// ---- verification/host_model.sv ----
// --------------------------------------------------------------
// host side: axi4-lite master issuing register accesses
// --------------------------------------------------------------
module host_model (
  input wire logic aclk,
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle bus at time zero, nothing offered
  initial begin
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'h0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
  end

  // one write; payload flips once taken so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    logic aw_pend;
    logic w_pend;
    aw_pend = 1'b1;
    w_pend = 1'b1;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
      if (aw_pend && s_axi_awready) begin
        aw_pend = 1'b0;
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (w_pend && s_axi_wready) begin
        w_pend = 1'b0;
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
    end
  endtask

  // one read; the answer is taken at the edge rvalid is seen
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    logic ar_pend;
    ar_pend = 1'b1;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
      if (ar_pend && s_axi_arready) begin
        ar_pend = 1'b0;
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
      end
    end
  endtask
endmodule

// ---- verification/tb_top.sv ----
// --------------------------------------------------------------
// command decoder bench with a behavioural reference
// --------------------------------------------------------------
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import cmd_decode_pkg::*;

  logic aclk;
  logic aresetn;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [5:0] subcmd;
  logic subcmd_strobe, lba_mode, max_option;
  int n_fail = 0;
  int samples_checked = 0;
  logic [31:0] seed = 32'h0000_003B;
  logic [31:0] v, x;
  logic [1:0] r;
  logic [7:0] o;
  logic [7:0] pick [5] = '{8'hB0, 8'hEF, 8'hF9, 8'hB1, 8'h37};
  // opcode, feature, expected subcommand code
  logic [31:0] tbl [33] = '{
    32'hB0D0_0001, 32'hB0D1_0002, 32'hB0D2_0003, 32'hB0D3_0004,
    32'hB0D4_0005, 32'hB0D5_0006, 32'hB0D6_0007, 32'hB0D8_0008,
    32'hB0D9_0009, 32'hB0DA_000A, 32'hB0DB_000B, 32'hEF02_0010,
    32'hEF82_0011, 32'hEF03_0012, 32'hEF05_0013, 32'hEF85_0014,
    32'hEF06_0015, 32'hEF86_0016, 32'hEF07_0017, 32'hEF10_0018,
    32'hEF90_0019, 32'hEFAA_001A, 32'hEF55_001B, 32'hEFCC_001C,
    32'hEF66_001D, 32'hF901_0020, 32'hF902_0021, 32'hF903_0022,
    32'hF904_0023, 32'hB1C0_0028, 32'hB1C1_0029, 32'hB1C2_002A,
    32'hB1C3_002B};

  ata_subcommand_power_query DUT (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .subcmd(subcmd),
    .subcmd_strobe(subcmd_strobe), .lba_mode(lba_mode),
    .max_option(max_option));

  host_model host (
    .aclk(aclk),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));

  // 200 mhz clock
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // xorshift source, fixed start so runs repeat
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // reference decode: listed opcodes abort on unknown features
  function automatic logic [7:0] model_sub(input logic [7:0] op, f);
    if (op == 8'hE5 || op == 8'h98) return 8'h30;
    foreach (tbl[i])
      if (tbl[i][31:16] == {op, f}) return tbl[i][7:0];
    if (op inside {8'hB0, 8'hEF, 8'hF9, 8'hB1}) return 8'h3F;
    return 8'h3E;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // issue one command and compare every visible result with the model
  task automatic run_cmd(input logic [7:0] op, f, sc, dv,
                         input logic [2:0] ds);
    logic [7:0] es;
    int n;
    es = model_sub(op, f);
    host.wr(ADDR_DRIVE, {29'h0, ds}, r);
    host.wr(ADDR_FEATURE, {24'h0, f}, r);
    host.wr(ADDR_SECCNT, {24'h0, sc}, r);
    host.wr(ADDR_DEVICE, {24'h0, dv}, r);
    host.wr(ADDR_COMMAND, {24'h0, op}, r);
    chk(32'(r), 32'h0000_0000);
    n = 0;
    while (subcmd_strobe !== 1'b1 && n < 20) begin
      @(posedge aclk);
      n++;
    end
    chk(32'(subcmd_strobe), 32'h0000_0001);
    chk(32'(subcmd), 32'(es));
    chk(32'(lba_mode), 32'(dv[6]));
    chk(32'(max_option), 32'((op == 8'hF9 || op == 8'h37) && sc[0]));
    @(posedge aclk);
    chk(32'(subcmd_strobe), 32'h0000_0000);
    host.rd(ADDR_STATUS, v, r);
    chk(v, (es == 8'h3F) ? 32'h0000_0041 : 32'h0000_0040);
    host.rd(ADDR_ERROR, v, r);
    chk(v, (es == 8'h3F) ? 32'h0000_0004 : 32'h0000_0000);
    host.rd(ADDR_RESULT, v, r);
    chk(v, 32'(es));
    host.rd(ADDR_SECCNT, v, r);
    if (es != 8'h30) chk(v, {24'h0, sc});
    else chk(v, (ds == 3'b001) ? 32'h0000_00FF : 32'h0000_0000);
  endtask

  // documented feature pairs, retry bit sent as zero
  task automatic run_range(input int lo, input int hi);
    logic [31:0] y;
    for (int i = lo; i <= hi; i++) begin
      y = rnd();
      run_cmd(tbl[i][31:24], tbl[i][23:16], y[7:0], {1'b0, y[14:8]},
              y[18:16]);
    end
  endtask

  // hang guard, far beyond the few thousand cycles the tests take
  initial begin
    #100us;
    n_fail++;
    final_report();
  end

  // main sequence
  initial begin
    aresetn = 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    for (int i = 0; i < 8; i++) begin
      host.rd(8'(i * 4), v, r);
      chk(v, (i == 5) ? 32'(STATUS_RESET) : 32'h0000_0000);
      chk(32'(r), 32'h0000_0000);
    end
    host.rd(8'h20, v, r);
    chk(v, 32'h0000_0000);
    chk(32'(r), 32'h0000_0002);
    host.wr(ADDR_STATUS, 32'h0000_00FF, r);
    chk(32'(r), 32'h0000_0000);
    // unmapped write is refused with a slave error
    host.wr(8'h20, 32'h0000_00FF, r);
    chk(32'(r), 32'h0000_0002);
    host.rd(ADDR_STATUS, v, r);
    chk(v, 32'(STATUS_RESET));
    $display("test reset_map done");
    run_range(0, 10);
    run_range(11, 24);
    run_range(25, 28);
    run_range(29, 32);
    $display("test subcommand_table done");
    // every drive state through both query opcodes
    for (int k = 0; k < 16; k++) begin
      x = rnd();
      o = k[3] ? 8'h98 : 8'hE5;
      run_cmd(o, x[7:0], x[15:8], {1'b0, x[22:16]}, 3'(k));
    end
    $display("test power_query done");
    // random opcodes and features, retry bit toggled freely
    for (int k = 0; k < 24; k++) begin
      x = rnd();
      o = (x[26:24] > 3'd4) ? x[31:24] : pick[x[26:24]];
      run_cmd(o, x[7:0], x[15:8], x[23:16], x[2:0]);
    end
    $display("test random_commands done");
    final_report();
  end
endmodule
